// File: hw/mic_defines.vh
// Constants for the meter input configuration menu
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH

`define MIC_CLK_MHZ 125
`define MIC_TICK_US 1000
`define MIC_ENTER_MS 3000
`define MIC_EXIT_MS 1000
`define MIC_BLINK_MS 500
`define MIC_CHATTER_MS 2
`define MIC_DEB_TICKS 2
`define MIC_TICK_CYCLES (`MIC_TICK_US * `MIC_CLK_MHZ)
`define MIC_ENTER_TICKS (`MIC_ENTER_MS * 1000 / `MIC_TICK_US)
`define MIC_EXIT_TICKS (`MIC_EXIT_MS * 1000 / `MIC_TICK_US)
`define MIC_BLINK_TICKS (`MIC_BLINK_MS * 1000 / `MIC_TICK_US)
`define MIC_CHATTER_TICKS (`MIC_CHATTER_MS * 1000 / `MIC_TICK_US)

`define MIC_OFF_STATUS 4'h0
`define MIC_OFF_CTRL 4'h1
`define MIC_OFF_READOUT 4'h2
`define MIC_OFF_INP1 4'h3
`define MIC_OFF_DSP1 4'h4
`define MIC_OFF_INP2 4'h5
`define MIC_OFF_DSP2 4'h6
`define MIC_OFF_PINP 4'h7
`define MIC_OFF_PDSP 4'h8
`define MIC_CTRL_ZERO_SET 0
`define MIC_CTRL_ZERO_CLR 1
`define MIC_CTRL_DL_EN 2

`define MIC_TYPE_ANALOG 2'h0
`define MIC_TYPE_PULSE 2'h1
`define MIC_TYPE_REMOTE 2'h2
`define MIC_RNG_4_20MA 2'h0
`define MIC_RNG_1_5V 2'h1
`define MIC_RNG_5V 2'h2
`define MIC_RNG_10V 2'h3
`define MIC_PRNG_30HZ 1'h0
`define MIC_PRNG_5KHZ 1'h1

`define MIC_PAR_TYPE 4'h0
`define MIC_PAR_ARANGE 4'h1
`define MIC_PAR_PRANGE 4'h2
`define MIC_PAR_INP1 4'h3
`define MIC_PAR_DSP1 4'h4
`define MIC_PAR_INP2 4'h5
`define MIC_PAR_DSP2 4'h6
`define MIC_PAR_PINP 4'h7
`define MIC_PAR_PDSP 4'h8
`define MIC_PAR_DP 4'h9

`define MIC_VAL_MIN 18'h3b1e1
`define MIC_VAL_MAX 18'h1869f
`define MIC_DP_MAX 3'h4
`define MIC_RST_TYPE 2'h0
`define MIC_RST_ARANGE 2'h0
`define MIC_RST_PRANGE 1'h1
`define MIC_ADEF_DSP1 18'h00000
`define MIC_ADEF_DSP2 18'h02710
`define MIC_ADEF_INP1_420 18'h00190
`define MIC_ADEF_INP2_420 18'h007d0
`define MIC_ADEF_INP1_15 18'h003e8
`define MIC_ADEF_INP2_15 18'h01388
`define MIC_ADEF_INP1_5 18'h3fe0c
`define MIC_ADEF_INP2_5 18'h001f4
`define MIC_ADEF_INP1_10 18'h3fc18
`define MIC_ADEF_INP2_10 18'h003e8
`define MIC_ADEF_DP 3'h1
`define MIC_PDEF_INP_LO 18'h00bb8
`define MIC_PDEF_INP_HI 18'h0c350
`define MIC_PDEF_DP_LO 3'h2
`define MIC_PDEF_DP_HI 3'h1

`endif

// File: hw/mic_key_hold.v
// Debounced front-panel key with press pulse and two hold thresholds
module mic_key_hold #(
	parameter DEB_TICKS = 2,
	parameter HOLD_A = 1000,
	parameter HOLD_B = 3000
) (
	input wire clock,
	input wire rstn,
	input wire tick,
	input wire key,
	output reg press_q,
	output reg hold_a_q,
	output reg hold_b_q
);
	reg [3:0] deb_cnt_q;
	reg deb_q;
	reg [11:0] hold_cnt_q;

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			deb_cnt_q <= 4'h0;
			deb_q <= 1'b0;
			hold_cnt_q <= 12'h000;
			press_q <= 1'b0;
			hold_a_q <= 1'b0;
			hold_b_q <= 1'b0;
		end
		else
		begin
			press_q <= 1'b0;
			hold_a_q <= 1'b0;
			hold_b_q <= 1'b0;
			if (tick)
			begin
				// Key must disagree for DEB_TICKS ticks before the state flips
				if (key == deb_q)
					deb_cnt_q <= 4'h0;
				else if (deb_cnt_q == DEB_TICKS[3:0] - 4'h1)
				begin
					deb_cnt_q <= 4'h0;
					deb_q <= key;
					press_q <= key;
				end
				else
					deb_cnt_q <= deb_cnt_q + 4'h1;
				// Released key restarts the hold count
				if (!deb_q)
					hold_cnt_q <= 12'h000;
				else if (hold_cnt_q != 12'hfff)
				begin
					hold_cnt_q <= hold_cnt_q + 12'h001;
					hold_a_q <= (hold_cnt_q == HOLD_A[11:0] - 12'h001);
					hold_b_q <= (hold_cnt_q == HOLD_B[11:0] - 12'h001);
				end
			end
		end
	end
endmodule

// File: hw/mic_scaler.v
// Two-point linear scaling of the live input to a readout
module mic_scaler #(
	parameter W = 18
) (
	input wire clock,
	input wire rstn,
	input wire signed [W-1:0] x,
	input wire signed [W-1:0] x1,
	input wire signed [W-1:0] y1,
	input wire signed [W-1:0] x2,
	input wire signed [W-1:0] y2,
	output reg signed [W-1:0] y_q
);
	wire signed [W:0] dx = {x[W-1], x} - {x1[W-1], x1};
	wire signed [W:0] dy = {y2[W-1], y2} - {y1[W-1], y1};
	wire signed [W:0] den = {x2[W-1], x2} - {x1[W-1], x1};
	wire signed [2*W+1:0] prod = dx * dy;
	// Negative dy gives the inverse slope without a separate path
	// Unsigned zero arm would turn the whole division unsigned
	wire signed [2*W+1:0] quo = (den == 0) ? $signed({(2*W+2){1'b0}}) : prod / den;

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			y_q <= {W{1'b0}};
		else
			y_q <= y1 + quo[W-1:0];
	end
endmodule

// File: hw/mic_top.v
// Initial setting level menu of the panel meter with Avalon-MM status access
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`include "mic_defines.vh"
module mic_top #(
	parameter TICK_CYCLES = `MIC_TICK_CYCLES,
	parameter W = 18
) (
	input wire clock,
	input wire rstn,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire key_level,
	input wire key_mode,
	input wire key_shift,
	input wire key_up,
	input wire pulse_in,
	input wire [W-1:0] process_value,
	output reg pulse_clean_q,
	output reg level_init_q,
	output reg set_value_indicator_q,
	output reg teach_led_q,
	output reg value_blink_q,
	output reg zero_led_q,
	output reg download_en_q,
	output reg [3:0] disp_param_q,
	output reg [W-1:0] disp_value_q,
	output reg [1:0] inp_decimals_q,
	output reg [W-1:0] readout_q
);
	localparam ST_OPER = 5'h01;
	localparam ST_PARAM = 5'h02;
	localparam ST_MONITOR = 5'h04;
	localparam ST_CHANGE = 5'h08;
	localparam ST_TEACH = 5'h10;

	reg [16:0] tick_cnt_q;
	reg tick_q;
	reg [9:0] blink_cnt_q;
	reg blink_q;
	reg [4:0] state_q;
	reg [3:0] idx_q;
	reg [W-1:0] edit_q;
	reg [1:0] in_type_q;
	reg [1:0] arange_q;
	reg prange_q;
	reg [2:0] dp_q;
	reg [W-1:0] inp1_q, dsp1_q, inp2_q, dsp2_q, pinp_q, pdsp_q;
	reg [W-1:0] zero_off_q;
	reg [3:0] chat_cnt_q;
	reg [W-1:0] cur_val;
	wire lvl_hold1, lvl_hold3;
	wire mode_p, shift_p, up_p;
	wire [W-1:0] scaled;

	function [3:0] next_par;
		input [3:0] i;
		begin
			next_par = (i == `MIC_PAR_DP) ? `MIC_PAR_TYPE : i + 4'h1;
		end
	endfunction

	function [W-1:0] inc_val;
		input [3:0] i;
		input [W-1:0] v;
		begin
			if (i == `MIC_PAR_TYPE)
				inc_val = (v[1:0] == `MIC_TYPE_REMOTE) ? {W{1'b0}} : v + 1'b1;
			else if (i == `MIC_PAR_ARANGE)
				inc_val = {{(W-2){1'b0}}, v[1:0] + 2'h1};
			else if (i == `MIC_PAR_PRANGE)
				inc_val = {{(W-1){1'b0}}, ~v[0]};
			else if (i == `MIC_PAR_DP)
				inc_val = (v[2:0] == `MIC_DP_MAX) ? {W{1'b0}} : v + 1'b1;
			else
				inc_val = (v == `MIC_VAL_MAX) ? `MIC_VAL_MIN : v + 1'b1;
		end
	endfunction

	// Analog range defaults: sel 0 first input, 1 second input
	function [W-1:0] adef;
		input [1:0] rng;
		input sel;
		begin
			if (rng == `MIC_RNG_4_20MA)
				adef = sel ? `MIC_ADEF_INP2_420 : `MIC_ADEF_INP1_420;
			else if (rng == `MIC_RNG_1_5V)
				adef = sel ? `MIC_ADEF_INP2_15 : `MIC_ADEF_INP1_15;
			else if (rng == `MIC_RNG_5V)
				adef = sel ? `MIC_ADEF_INP2_5 : `MIC_ADEF_INP1_5;
			else
				adef = sel ? `MIC_ADEF_INP2_10 : `MIC_ADEF_INP1_10;
		end
	endfunction

	function teachable;
		input [3:0] i;
		begin
			teachable = (i == `MIC_PAR_INP1) || (i == `MIC_PAR_INP2) || (i == `MIC_PAR_PINP);
		end
	endfunction

	// Bus handshake: one wait cycle, then a single cycle with waitrequest low
	wire bus_req = avs_read | avs_write;
	wire bus_wr = avs_write & ~avs_waitrequest;
	wire wr_ctrl = bus_wr & (avs_address == `MIC_OFF_CTRL);
	wire zero_set = wr_ctrl & avs_writedata[`MIC_CTRL_ZERO_SET];
	wire zero_clr = wr_ctrl & avs_writedata[`MIC_CTRL_ZERO_CLR];
	wire commit = (state_q == ST_CHANGE) & mode_p;
	wire type_chg = commit & (idx_q == `MIC_PAR_TYPE) & (edit_q[1:0] != in_type_q);
	wire arange_chg = commit & (idx_q == `MIC_PAR_ARANGE) & (edit_q[1:0] != arange_q);
	wire prange_chg = commit & (idx_q == `MIC_PAR_PRANGE) & (edit_q[0] != prange_q);
	wire pulse_mode = (in_type_q == `MIC_TYPE_PULSE);

	always @*
	begin
		if (idx_q == `MIC_PAR_TYPE)
			cur_val = {{(W-2){1'b0}}, in_type_q};
		else if (idx_q == `MIC_PAR_ARANGE)
			cur_val = {{(W-2){1'b0}}, arange_q};
		else if (idx_q == `MIC_PAR_PRANGE)
			cur_val = {{(W-1){1'b0}}, prange_q};
		else if (idx_q == `MIC_PAR_INP1)
			cur_val = inp1_q;
		else if (idx_q == `MIC_PAR_DSP1)
			cur_val = dsp1_q;
		else if (idx_q == `MIC_PAR_INP2)
			cur_val = inp2_q;
		else if (idx_q == `MIC_PAR_DSP2)
			cur_val = dsp2_q;
		else if (idx_q == `MIC_PAR_PINP)
			cur_val = pinp_q;
		else if (idx_q == `MIC_PAR_PDSP)
			cur_val = pdsp_q;
		else
			cur_val = {{(W-3){1'b0}}, dp_q};
	end

	mic_key_hold #(.DEB_TICKS(`MIC_DEB_TICKS), .HOLD_A(`MIC_EXIT_TICKS), .HOLD_B(`MIC_ENTER_TICKS)) u_key_level (
		.clock(clock), .rstn(rstn), .tick(tick_q), .key(key_level),
		.press_q(), .hold_a_q(lvl_hold1), .hold_b_q(lvl_hold3));
	mic_key_hold #(.DEB_TICKS(`MIC_DEB_TICKS)) u_key_mode (
		.clock(clock), .rstn(rstn), .tick(tick_q), .key(key_mode),
		.press_q(mode_p), .hold_a_q(), .hold_b_q());
	mic_key_hold #(.DEB_TICKS(`MIC_DEB_TICKS)) u_key_shift (
		.clock(clock), .rstn(rstn), .tick(tick_q), .key(key_shift),
		.press_q(shift_p), .hold_a_q(), .hold_b_q());
	mic_key_hold #(.DEB_TICKS(`MIC_DEB_TICKS)) u_key_up (
		.clock(clock), .rstn(rstn), .tick(tick_q), .key(key_up),
		.press_q(up_p), .hold_a_q(), .hold_b_q());

	// Pulse input scales against zero so one point pair is enough
	mic_scaler #(.W(W)) u_scaler (
		.clock(clock), .rstn(rstn), .x(process_value),
		.x1(pulse_mode ? {W{1'b0}} : inp1_q), .y1(pulse_mode ? {W{1'b0}} : dsp1_q),
		.x2(pulse_mode ? pinp_q : inp2_q), .y2(pulse_mode ? pdsp_q : dsp2_q),
		.y_q(scaled));

	// System tick and blink phase
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_cnt_q <= 17'h00000;
			tick_q <= 1'b0;
			blink_cnt_q <= 10'h000;
			blink_q <= 1'b0;
		end
		else
		begin
			tick_q <= (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001);
			tick_cnt_q <= (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001) ? 17'h00000 : tick_cnt_q + 17'h00001;
			if (tick_q)
			begin
				if (blink_cnt_q == `MIC_BLINK_TICKS - 1)
				begin
					blink_cnt_q <= 10'h000;
					blink_q <= ~blink_q;
				end
				else
					blink_cnt_q <= blink_cnt_q + 10'h001;
			end
		end
	end

	// Chatter filter only in the low pulse range; relay bounce dies within a few ms
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			chat_cnt_q <= 4'h0;
			pulse_clean_q <= 1'b0;
		end
		else if (prange_q == `MIC_PRNG_5KHZ)
		begin
			chat_cnt_q <= 4'h0;
			pulse_clean_q <= pulse_in;
		end
		else if (pulse_in == pulse_clean_q)
			chat_cnt_q <= 4'h0;
		else if (tick_q)
		begin
			if (chat_cnt_q == `MIC_CHATTER_TICKS - 1)
			begin
				chat_cnt_q <= 4'h0;
				pulse_clean_q <= pulse_in;
			end
			else
				chat_cnt_q <= chat_cnt_q + 4'h1;
		end
	end

	// Menu walk, parameter storage and forced zero
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ST_OPER;
			idx_q <= `MIC_PAR_TYPE;
			edit_q <= {W{1'b0}};
			in_type_q <= `MIC_RST_TYPE;
			arange_q <= `MIC_RST_ARANGE;
			prange_q <= `MIC_RST_PRANGE;
			dp_q <= `MIC_ADEF_DP;
			inp1_q <= `MIC_ADEF_INP1_420;
			dsp1_q <= `MIC_ADEF_DSP1;
			inp2_q <= `MIC_ADEF_INP2_420;
			dsp2_q <= `MIC_ADEF_DSP2;
			pinp_q <= `MIC_PDEF_INP_HI;
			pdsp_q <= `MIC_PDEF_INP_HI;
			zero_off_q <= {W{1'b0}};
			zero_led_q <= 1'b0;
			download_en_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				download_en_q <= avs_writedata[`MIC_CTRL_DL_EN];
			if (zero_set && !pulse_mode)
			begin
				zero_off_q <= scaled;
				zero_led_q <= 1'b1;
			end
			case (state_q)
				ST_OPER:
					if (lvl_hold3)
					begin
						state_q <= ST_PARAM;
						idx_q <= `MIC_PAR_TYPE;
					end
				ST_PARAM:
					if (shift_p)
						state_q <= ST_MONITOR;
					else if (mode_p)
						idx_q <= next_par(idx_q);
				ST_MONITOR:
					if (shift_p)
					begin
						state_q <= ST_CHANGE;
						edit_q <= cur_val;
					end
					else if (up_p && teachable(idx_q))
						state_q <= ST_TEACH;
					else if (mode_p)
					begin
						state_q <= ST_PARAM;
						idx_q <= next_par(idx_q);
					end
				ST_CHANGE:
					if (up_p)
						edit_q <= inc_val(idx_q, edit_q);
					else if (mode_p)
					begin
						state_q <= ST_PARAM;
						idx_q <= next_par(idx_q);
					end
				ST_TEACH:
					if (up_p)
					begin
						state_q <= ST_MONITOR;
						if (idx_q == `MIC_PAR_INP1)
							inp1_q <= process_value;
						else if (idx_q == `MIC_PAR_INP2)
							inp2_q <= process_value;
						else
							pinp_q <= process_value;
					end
					else if (mode_p)
					begin
						state_q <= ST_PARAM;
						idx_q <= next_par(idx_q);
					end
				default:
					state_q <= ST_OPER;
			endcase
			// Exit wins the next state over any key event of the same cycle; a commit or teach store of that cycle still lands
			if (state_q != ST_OPER && lvl_hold1)
				state_q <= ST_OPER;
			if (commit)
			begin
				if (idx_q == `MIC_PAR_TYPE)
					in_type_q <= edit_q[1:0];
				else if (idx_q == `MIC_PAR_ARANGE)
					arange_q <= edit_q[1:0];
				else if (idx_q == `MIC_PAR_PRANGE)
					prange_q <= edit_q[0];
				else if (idx_q == `MIC_PAR_INP1)
					inp1_q <= edit_q;
				else if (idx_q == `MIC_PAR_DSP1)
					dsp1_q <= edit_q;
				else if (idx_q == `MIC_PAR_INP2)
					inp2_q <= edit_q;
				else if (idx_q == `MIC_PAR_DSP2)
					dsp2_q <= edit_q;
				else if (idx_q == `MIC_PAR_PINP)
					pinp_q <= edit_q;
				else if (idx_q == `MIC_PAR_PDSP)
					pdsp_q <= edit_q;
				else
					dp_q <= edit_q[2:0];
			end
			// Reloads below override the plain store of the same commit
			if ((type_chg && edit_q[1:0] == `MIC_TYPE_ANALOG) || arange_chg)
			begin
				inp1_q <= adef(type_chg ? arange_q : edit_q[1:0], 1'b0);
				inp2_q <= adef(type_chg ? arange_q : edit_q[1:0], 1'b1);
				dsp1_q <= `MIC_ADEF_DSP1;
				dsp2_q <= `MIC_ADEF_DSP2;
				dp_q <= `MIC_ADEF_DP;
			end
			if (type_chg && edit_q[1:0] == `MIC_TYPE_PULSE)
				dp_q <= prange_q ? `MIC_PDEF_DP_HI : `MIC_PDEF_DP_LO;
			if (type_chg && edit_q[1:0] == `MIC_TYPE_REMOTE)
			begin
				inp1_q <= `MIC_VAL_MIN;
				dsp1_q <= `MIC_VAL_MIN;
				inp2_q <= `MIC_VAL_MAX;
				dsp2_q <= `MIC_VAL_MAX;
				dp_q <= 3'h0;
				download_en_q <= 1'b1;
			end
			if (prange_chg)
			begin
				pinp_q <= edit_q[0] ? `MIC_PDEF_INP_HI : `MIC_PDEF_INP_LO;
				pdsp_q <= edit_q[0] ? `MIC_PDEF_INP_HI : `MIC_PDEF_INP_LO;
				dp_q <= edit_q[0] ? `MIC_PDEF_DP_HI : `MIC_PDEF_DP_LO;
			end
			if (zero_clr || (type_chg && edit_q[1:0] != `MIC_TYPE_PULSE) || arange_chg)
			begin
				zero_off_q <= {W{1'b0}};
				zero_led_q <= 1'b0;
			end
		end
	end

	// Panel outputs
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			level_init_q <= 1'b0;
			set_value_indicator_q <= 1'b0;
			teach_led_q <= 1'b0;
			value_blink_q <= 1'b0;
			disp_param_q <= `MIC_PAR_TYPE;
			disp_value_q <= {W{1'b0}};
			inp_decimals_q <= 2'h0;
			readout_q <= {W{1'b0}};
		end
		else
		begin
			level_init_q <= (state_q != ST_OPER);
			set_value_indicator_q <= (state_q == ST_MONITOR) || (state_q == ST_CHANGE);
			teach_led_q <= teachable(idx_q) && ((state_q == ST_PARAM) || (state_q == ST_MONITOR) ||
				((state_q == ST_TEACH) && blink_q));
			value_blink_q <= (state_q == ST_CHANGE) && blink_q;
			disp_param_q <= idx_q;
			disp_value_q <= (state_q == ST_CHANGE) ? edit_q : (state_q == ST_TEACH) ? process_value : cur_val;
			if (in_type_q == `MIC_TYPE_ANALOG)
				inp_decimals_q <= (arange_q == `MIC_RNG_1_5V) ? 2'h3 : 2'h2;
			else
				inp_decimals_q <= 2'h0;
			readout_q <= scaled - zero_off_q;
		end
	end

	// Avalon-MM slave
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end
		else if (bus_req && avs_waitrequest)
		begin
			avs_waitrequest <= 1'b0;
			if (avs_address == `MIC_OFF_STATUS)
				avs_readdata <= {10'h000, download_en_q, zero_led_q, dp_q, prange_q, arange_q,
					in_type_q, idx_q, 3'h0, state_q};
			else if (avs_address == `MIC_OFF_CTRL)
				avs_readdata <= {29'h00000000, download_en_q, 2'h0};
			else if (avs_address == `MIC_OFF_READOUT)
				avs_readdata <= {{(32-W){readout_q[W-1]}}, readout_q};
			else if (avs_address == `MIC_OFF_INP1)
				avs_readdata <= {{(32-W){inp1_q[W-1]}}, inp1_q};
			else if (avs_address == `MIC_OFF_DSP1)
				avs_readdata <= {{(32-W){dsp1_q[W-1]}}, dsp1_q};
			else if (avs_address == `MIC_OFF_INP2)
				avs_readdata <= {{(32-W){inp2_q[W-1]}}, inp2_q};
			else if (avs_address == `MIC_OFF_DSP2)
				avs_readdata <= {{(32-W){dsp2_q[W-1]}}, dsp2_q};
			else if (avs_address == `MIC_OFF_PINP)
				avs_readdata <= {{(32-W){pinp_q[W-1]}}, pinp_q};
			else if (avs_address == `MIC_OFF_PDSP)
				avs_readdata <= {{(32-W){pdsp_q[W-1]}}, pdsp_q};
			else
				avs_readdata <= 32'h00000000;
		end
		else
			avs_waitrequest <= 1'b1;
	end
endmodule

// File: verif/mic_top_sva.sv
// Port-level checker for the meter menu block
`include "mic_defines.vh"
module mic_chk #(
	parameter TICK_CYCLES = 10
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic key_level,
	input wire logic level_init_q,
	input wire logic set_value_indicator_q,
	input wire logic teach_led_q,
	input wire logic value_blink_q,
	input wire logic zero_led_q,
	input wire logic [3:0] disp_param_q
);
	localparam int ENTER_MIN = (`MIC_ENTER_TICKS - 2) * TICK_CYCLES;
	localparam int EXIT_MIN = (`MIC_EXIT_TICKS - 2) * TICK_CYCLES;
	logic [31:0] hold_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Raw hold time; debounce only delays the level change, so two ticks of slack
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			hold_q <= 32'h0;
		else
			hold_q <= key_level ? hold_q + 32'h1 : 32'h0;
	end
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered in one cycle");
	a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_bus_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h8 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_zero_clear: assert property (avs_write && !avs_waitrequest && avs_address == 4'h1 && avs_writedata[1]
		|=> !zero_led_q) else $error("zero indicator not cleared");
	a_enter_hold: assert property ($rose(level_init_q) |-> hold_q >= ENTER_MIN)
		else $error("initial level entered before three seconds");
	a_exit_hold: assert property ($fell(level_init_q) |-> hold_q >= EXIT_MIN)
		else $error("initial level left before one second");
	a_entry_first: assert property ($rose(level_init_q) |-> disp_param_q == 4'h0)
		else $error("entry does not show input type");
	a_mode_step: assert property (level_init_q && $past(level_init_q) && $changed(disp_param_q)
		&& $past(disp_param_q) != 4'h9 |-> disp_param_q == $past(disp_param_q) + 4'h1)
		else $error("parameter did not step by one");
	a_blink_change: assert property (value_blink_q |-> set_value_indicator_q)
		else $error("blink outside change state");
	a_quiet_oper: assert property (!level_init_q |-> !set_value_indicator_q && !teach_led_q)
		else $error("menu indicator lit in operation level");
	a_teach_param: assert property (teach_led_q |-> disp_param_q inside {4'h3, 4'h5, 4'h7})
		else $error("teach indicator on a parameter that cannot be taught");
	c_enter: cover property ($rose(level_init_q));
	c_exit: cover property ($fell(level_init_q));
	c_teach: cover property (teach_led_q && set_value_indicator_q);
endmodule
bind mic_top mic_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .key_level(key_level), .level_init_q(level_init_q),
	.set_value_indicator_q(set_value_indicator_q), .teach_led_q(teach_led_q), .value_blink_q(value_blink_q),
	.zero_led_q(zero_led_q), .disp_param_q(disp_param_q));

// File: verif/mic_op.sv
// Operator model pressing the front-panel keys
module mic_op #(
	parameter TICK_CYCLES = 10
) (
	input wire logic clock,
	output logic [3:0] keys
);
	timeunit 1ns;
	timeprecision 1ps;
	initial keys = 4'h0;
	// Quiet gap after release so the debouncer sees the key up before the next press
	task automatic push(input int k, input int n);
		keys[k] <= 1'b1;
		repeat (n * TICK_CYCLES) @(posedge clock);
		keys[k] <= 1'b0;
		repeat (6 * TICK_CYCLES) @(posedge clock);
	endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the meter menu block
`include "mic_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic pulse_in = 1'b0;
	logic [17:0] process_value = 18'h0;
	logic [15:0] lfsr_q = 16'h45;
	logic [15:0] pv;
	logic [35:0] note;
	logic [35:0] exp_q[$];
	logic [31:0] avs_readdata;
	logic [17:0] disp_value_q;
	logic [1:0] inp_decimals_q;
	logic [3:0] keys;
	logic avs_waitrequest, level_init_q, teach_led_q, zero_led_q;
	logic pulse_clean_q;
	logic pin_q = 1'b0;
	logic pthru = 1'b0;
	int err_total = 0;
	int checks = 0;
	mic_top #(.TICK_CYCLES(TK)) uut (.clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .key_level(keys[0]), .key_mode(keys[1]), .key_shift(keys[2]),
		.key_up(keys[3]), .pulse_in(pulse_in), .process_value(process_value), .pulse_clean_q(pulse_clean_q),
		.level_init_q(level_init_q), .set_value_indicator_q(), .teach_led_q(teach_led_q), .value_blink_q(),
		.zero_led_q(zero_led_q), .download_en_q(), .disp_param_q(), .disp_value_q(disp_value_q),
		.inp_decimals_q(inp_decimals_q), .readout_q());
	mic_op #(.TICK_CYCLES(TK)) u_op (.clock(clock), .keys(keys));
	always #4 clock = ~clock;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] st(input logic [3:0] i, input logic [4:0] s, input logic [1:0] ty,
		input logic [1:0] ar, input logic [2:0] dp, input logic z, input logic dl);
		return {10'h0, dl, z, dp, 1'b1, ar, ty, i, 3'h0, s};
	endfunction
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back({a, e});
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic tap(input int k);
		u_op.push(k, 4);
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock)
	begin
		lfsr_q <= lfsr(lfsr_q);
		pulse_in <= lfsr_q[0];
		pin_q <= pulse_in;
		if (pthru)
			cmp("pulse_clean_q", {31'h0, pin_q}, {31'h0, pulse_clean_q});
		if (avs_read && avs_waitrequest === 1'b0)
		begin
			note = exp_q.pop_front();
			cmp($sformatf("readdata at %h", note[35:32]), note[31:0], avs_readdata);
		end
	end
	initial
	begin
		repeat (90000) @(posedge clock);
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		pthru <= 1'b1;
		rd(`MIC_OFF_STATUS, st(4'h0, 5'h01, 2'h0, 2'h0, 3'h1, 1'b0, 1'b0));
		rd(4'hf, 32'h0);
		wr(`MIC_OFF_INP1, 32'h5);
		wr(`MIC_OFF_CTRL, 32'h1);
		rd(`MIC_OFF_INP1, 32'h190);
		u_op.push(0, 300);
		rd(`MIC_OFF_STATUS, st(4'h0, 5'h01, 2'h0, 2'h0, 3'h1, 1'b1, 1'b0));
		u_op.push(0, 3010);
		rd(`MIC_OFF_STATUS, st(4'h0, 5'h02, 2'h0, 2'h0, 3'h1, 1'b1, 1'b0));
		// Type stays analog before the range is picked
		tap(1);
		tap(2);
		tap(2);
		tap(3);
		rd(`MIC_OFF_STATUS, st(4'h1, 5'h08, 2'h0, 2'h0, 3'h1, 1'b1, 1'b0));
		tap(1);
		rd(`MIC_OFF_STATUS, st(4'h2, 5'h02, 2'h0, 2'h1, 3'h1, 1'b0, 1'b0));
		rd(`MIC_OFF_INP1, 32'h3e8);
		rd(`MIC_OFF_INP2, 32'h1388);
		cmp("inp_decimals_q", 32'h3, {30'h0, inp_decimals_q});
		cmp("zero_led_q", 32'h0, {31'h0, zero_led_q});
		tap(1);
		cmp("teach_led_q", 32'h1, {31'h0, teach_led_q});
		tap(2);
		pv = lfsr_q;
		process_value <= {2'h0, pv};
		tap(3);
		cmp("disp_value_q", {16'h0, pv}, {14'h0, disp_value_q});
		tap(3);
		rd(`MIC_OFF_STATUS, st(4'h3, 5'h04, 2'h0, 2'h1, 3'h1, 1'b0, 1'b0));
		rd(`MIC_OFF_INP1, {16'h0, pv});
		tap(1);
		tap(1);
		tap(2);
		tap(3);
		tap(1);
		rd(`MIC_OFF_STATUS, st(4'h6, 5'h02, 2'h0, 2'h1, 3'h1, 1'b0, 1'b0));
		rd(`MIC_OFF_INP2, 32'h1388);
		u_op.push(0, 1010);
		cmp("level_init_q", 32'h0, {31'h0, level_init_q});
		wr(`MIC_OFF_CTRL, 32'h1);
		u_op.push(0, 3010);
		rd(`MIC_OFF_STATUS, st(4'h0, 5'h02, 2'h0, 2'h1, 3'h1, 1'b1, 1'b0));
		tap(2);
		tap(2);
		tap(3);
		tap(3);
		tap(1);
		rd(`MIC_OFF_STATUS, st(4'h1, 5'h02, 2'h2, 2'h1, 3'h0, 1'b0, 1'b1));
		for (int a = 3; a < 7; a++)
			rd(a[3:0], a < 5 ? 32'hffffb1e1 : 32'h1869f);
		wr(`MIC_OFF_CTRL, 32'h5);
		rd(`MIC_OFF_STATUS, st(4'h1, 5'h02, 2'h2, 2'h1, 3'h0, 1'b1, 1'b1));
		rd(`MIC_OFF_READOUT, 32'h0);
		wr(`MIC_OFF_CTRL, 32'h6);
		rd(`MIC_OFF_STATUS, st(4'h1, 5'h02, 2'h2, 2'h1, 3'h0, 1'b0, 1'b1));
		rd(`MIC_OFF_READOUT, {16'h0, pv});
		tap(1);
		tap(2);
		tap(2);
		tap(3);
		pthru <= 1'b0;
		tap(1);
		rd(`MIC_OFF_STATUS, st(4'h3, 5'h02, 2'h2, 2'h1, 3'h2, 1'b0, 1'b1) ^ 32'h00010000);
		rd(`MIC_OFF_PINP, 32'hbb8);
		rd(`MIC_OFF_PDSP, 32'hbb8);
		tally_and_finish();
	end
endmodule
